/* File: core/msl_link.sv */
// manchester serial command link: frame decode, error flags, read response
`timescale 1ns/100ps
`default_nettype none
module msl_link (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         vcc_rx,
  input  wire logic [1:0]   die_id,
  input  wire logic [15:0]  rd_word,
  output logic [5:0]        rd_addr,
  output logic              pin_out,
  output logic              pin_oe,
  output logic              comm_mode
);
  import msl_pkg::*;

  typedef enum {FR_IDLE, FR_RECV} msl_fr_st_t;
  typedef enum {TX_IDLE, TX_WAIT, TX_SEND} msl_tx_st_t;

  logic [2:0]       s1_q, s2_q;
  logic [1:0]       die;
  msl_rxbit_t       rx;
  logic [CNT_W-1:0] half;

  msl_fr_st_t       fr_st_q, fr_st_d;
  logic [5:0]       n_q, n_d, addr_q, addr_d;
  logic [31:0]      fr_q, fr_d, fr_new;
  logic             rw_q, rw_d, mode_q, mode_d, bc_q, bc_d;
  logic             ae_q, ae_d, ovr_q, ovr_d, crc_q, crc_d;
  logic             done, chk, ok, sel, crc_ok, go;
  logic             ae_s, ovr_s, crc_s, acc_hit, exit_hit;
  logic [1:0]       sync;
  logic [3:0]       tgt;
  logic [5:0]       a;
  logic [15:0]      data;

  msl_tx_st_t       tx_st_q, tx_st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, hb_q, hb_d, lim;
  logic             ph_q, ph_d, oe_q, oe_d, po_q, busy, load;
  logic [4:0]       nb_q, nb_d;
  logic [26:0]      sh_q, sh_d, resp;
  msl_status_t      st;
  logic [15:0]      dw;
  logic [21:0]      pl;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else if (clk_en) begin
      s1_q <= {vcc_rx, die_id};
      s2_q <= s1_q;
    end
  end

  assign die = s2_q[1:0];

  msl_mrx u_rx (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .line    (s2_q[2]),
    .rx      (rx),
    .half    (half)
  );

  // ****************************************************************
  // frame assembly and command decode
  // ****************************************************************
  always_comb begin
    fr_new  = {fr_q[30:0], rx.val};
    fr_st_d = fr_st_q;
    n_d     = n_q;
    fr_d    = fr_q;
    rw_d    = rw_q;
    done    = 1'b0;
    case (fr_st_q)
      FR_IDLE: begin
        if (rx.start) begin
          fr_st_d = FR_RECV;
          n_d     = '0;
        end
      end
      FR_RECV: begin
        if (rx.tmo) begin
          fr_st_d = FR_IDLE;
        end else if (rx.vld) begin
          fr_d = fr_new;
          n_d  = n_q + 6'h01;
          if (n_q == RW_IDX) begin
            rw_d = rx.val;
          end
          if (n_q > RW_IDX && n_d == (rw_q ? LEN_READ : LEN_WRITE)) begin
            fr_st_d = FR_IDLE;
            done    = 1'b1;
          end
        end
      end
      default: fr_st_d = FR_IDLE;
    endcase
    if (rw_q) begin
      sync   = fr_new[15:14];
      tgt    = fr_new[12:9];
      a      = fr_new[8:3];
      data   = '0;
      crc_ok = crc3({19'h0, fr_new[13:3]}, CRC_BITS_RD) == fr_new[2:0];
    end else begin
      sync   = fr_new[31:30];
      tgt    = fr_new[28:25];
      a      = fr_new[24:19];
      data   = fr_new[18:3];
      crc_ok = crc3({3'h0, fr_new[29:3]}, CRC_BITS_WR) == fr_new[2:0];
    end
    sel      = (tgt == TGT_BCAST) || tgt[die];
    ovr_s    = done && mode_q && busy;
    chk      = done && !(mode_q && busy);
    ae_s     = mode_q && ((fr_st_q == FR_RECV && rx.tmo) || (chk && sync != SYNC_CODE));
    crc_s    = mode_q && chk && sync == SYNC_CODE && !crc_ok;
    ok       = chk && sync == SYNC_CODE && crc_ok;
    acc_hit  = ok && !rw_q && a == ACCESS_ADDR && data == ACCESS_CODE;
    exit_hit = ok && !rw_q && a == ACCESS_ADDR && data != ACCESS_CODE;
    // respond only when selected in mode
    go       = ok && rw_q && mode_q && sel;
    mode_d   = mode_q;
    if (acc_hit) begin
      mode_d = 1'b1;
    end else if (exit_hit) begin
      mode_d = 1'b0;
    end
    addr_d = addr_q;
    bc_d   = bc_q;
    if (go) begin
      addr_d = a;
      bc_d   = (tgt == TGT_BCAST);
    end
    // set wins over the clear made by a response load
    ae_d  = (ae_q & ~load) | ae_s;
    ovr_d = (ovr_q & ~load) | ovr_s;
    crc_d = (crc_q & ~load) | crc_s;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fr_st_q <= FR_IDLE;
      n_q     <= '0;
      fr_q    <= '0;
      rw_q    <= 1'b0;
      mode_q  <= 1'b0;
      addr_q  <= ADDR_RST;
      bc_q    <= 1'b0;
      ae_q    <= 1'b0;
      ovr_q   <= 1'b0;
      crc_q   <= 1'b0;
    end else if (clk_en) begin
      fr_st_q <= fr_st_d;
      n_q     <= n_d;
      fr_q    <= fr_d;
      rw_q    <= rw_d;
      mode_q  <= mode_d;
      addr_q  <= addr_d;
      bc_q    <= bc_d;
      ae_q    <= ae_d;
      ovr_q   <= ovr_d;
      crc_q   <= crc_d;
    end
  end

  // ****************************************************************
  // read response transmitter
  // ****************************************************************
  always_comb begin
    busy   = tx_st_q != TX_IDLE;
    st.id  = die;
    st.bc  = bc_q;
    st.ae  = ae_q;
    st.ovr = ovr_q;
    st.crc = crc_q;
    dw     = addr_q[0] ? {8'h00, rd_word[7:0]} : rd_word;
    pl     = {st, dw};
    resp   = {SYNC_CODE, pl, crc3({8'h00, pl}, CRC_BITS_RESP)};
    lim    = (tx_st_q == TX_SEND) ? hb_q - 16'h0001 : half - 16'h0001;
    tx_st_d = tx_st_q;
    cnt_d   = cnt_q + 16'h0001;
    hb_d    = hb_q;
    ph_d    = ph_q;
    nb_d    = nb_q;
    sh_d    = sh_q;
    load    = 1'b0;
    case (tx_st_q)
      TX_IDLE: begin
        cnt_d = '0;
        if (go) begin
          tx_st_d = TX_WAIT;
        end
      end
      TX_WAIT: begin
        // start one half cell after last mid edge
        if (cnt_q >= lim) begin
          load    = 1'b1;
          tx_st_d = TX_SEND;
          cnt_d   = '0;
          hb_d    = half;
          ph_d    = 1'b0;
          nb_d    = '0;
          sh_d    = resp;
        end
      end
      TX_SEND: begin
        if (cnt_q >= lim) begin
          cnt_d = '0;
          ph_d  = ~ph_q;
          if (ph_q) begin
            sh_d = {sh_q[25:0], 1'b0};
            nb_d = nb_q + 5'h01;
            if (nb_q == RESP_LAST) begin
              tx_st_d = TX_IDLE;
            end
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
    oe_d = (tx_st_d == TX_SEND) && (ph_d ? sh_d[26] : ~sh_d[26]);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_q <= TX_IDLE;
      cnt_q   <= '0;
      hb_q    <= 16'h0001;
      ph_q    <= 1'b0;
      nb_q    <= '0;
      sh_q    <= '0;
      oe_q    <= 1'b0;
      po_q    <= 1'b0;
    end else if (clk_en) begin
      tx_st_q <= tx_st_d;
      cnt_q   <= cnt_d;
      hb_q    <= hb_d;
      ph_q    <= ph_d;
      nb_q    <= nb_d;
      sh_q    <= sh_d;
      oe_q    <= oe_d;
      // open drain: the pin is only ever pulled low
      po_q    <= 1'b0;
    end
  end

  assign rd_addr   = addr_q;
  assign pin_out   = po_q;
  assign pin_oe    = oe_q;
  assign comm_mode = mode_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  AST_PIN_LOW:
    assert property (pin_out == 1'b0 && (!pin_oe || busy)) else $error("open-drain pin misused");
  AST_EXIT_MODE:
    assert property (clk_en && exit_hit |=> !comm_mode) else $error("exit code did not end mode");
  AST_ENTRY_ONLY:
    assert property ($rose(mode_q) |-> $past(acc_hit && clk_en)) else $error("mode entered without access");
  AST_NO_RSP_OFF:
    assert property (clk_en && !mode_q && tx_st_q == TX_IDLE |=> tx_st_q == TX_IDLE)
      else $error("response outside serial mode");
  AST_UNSELECTED:
    assert property (clk_en && done && rw_q && !sel |=> tx_st_q == TX_IDLE || $past(busy))
      else $error("unselected die answered");
  AST_ADDR_LATCH:
    assert property (clk_en && go |=> rd_addr == $past(a)) else $error("read address not latched");
  AST_EVEN_DATA:
    assert property (clk_en && load && !addr_q[0] |=> sh_q[18:3] == $past(rd_word)) else $error("even read data wrong");
  AST_ODD_DATA:
    assert property (clk_en && load && addr_q[0] |=> sh_q[18:11] == 8'h00 && sh_q[10:3] == $past(rd_word[7:0]))
      else $error("odd read data wrong");
  AST_HEAD:
    assert property (clk_en && load |=> sh_q[26:25] == SYNC_CODE && sh_q[24:23] == $past(die)) else $error("bad header");
  AST_BC_FLAG:
    assert property (clk_en && go |=> bc_q == ($past(tgt) == TGT_BCAST)) else $error("broadcast flag wrong");
  AST_AE_CLEAR:
    assert property (clk_en && load && !ae_s |=> !ae_q) else $error("abort flag not cleared");
  AST_OVR_SET:
    assert property (clk_en && ovr_s |=> ovr_q && (sh_q[20] == $past(ovr_q) || !$past(load)))
      else $error("overrun lost");
  AST_CRC_SET:
    assert property (clk_en && crc_s |=> crc_q) else $error("crc error flag not set");
  AST_RSP_CRC:
    assert property (clk_en && load |=> sh_q[2:0] == crc3({8'h00, sh_q[24:3]}, CRC_BITS_RESP))
      else $error("response crc wrong");
  AST_GO_WAIT:
    assert property (clk_en && go |=> tx_st_q == TX_WAIT && cnt_q == '0) else $error("response start lost");

  COV_ENTRY:    cover property ($rose(mode_q));
  COV_RESPONSE: cover property (clk_en && load);
  COV_OVERRUN:  cover property (clk_en && ovr_s);
  COV_EXIT:     cover property (clk_en && exit_hit);

endmodule // msl_link
`default_nettype wire

/* File: core/msl_pkg.sv */
// package: constants, types and crc for the manchester serial command link
// ****************************************************************************
// Operation
// - exit-code frames act as broadcast, whatever the target field holds
// - exit frame: sync 00, rw 0, any target, address 111111, data not 0x62d2, crc
// - a valid exit frame ends serial mode; reads unanswered until the next access frame
// - read command latches its address for the following read response
// - read commands ignored, no response, until access code entered serial mode
// - read frame: sync 00, rw 1, 4-bit target, 6-bit address, 3-bit crc
// - response sent by pulling open-drain pin low or releasing it
// - even address returns even byte in 15:8, odd byte in 7:0
// - odd address returns odd byte in 7:0, bits 15:8 forced zero
// - response: sync 00, die id, bc/ae/or/cs flags, 16 data bits, crc
// - die id field encodes die zero to three as 00 to 11
// - broadcast flag is 1 when read target field was 0000
// - aborted frame sets abort flag, reported in next response, then cleared
// - command completed during response sets overrun flag, reported then cleared
// - bad crc sets crc-error flag, reported in next response, then cleared
// - response starts within a quarter bit of the command's last crc bit end
// - manchester: one is falling edge mid-cell, zero is rising edge mid-cell
// - crc x^3+x+1, seed 111, bits after sync msb first, sent c2 first
// - serial mode entered only by access frame, address 111111, data 0x62d2
// - target bit selects die of that id; target 0000 addresses all dies
// ****************************************************************************
package msl_pkg;

  localparam int               CNT_W         = 16;
  localparam logic [CNT_W-1:0] CNT_MAX       = 16'hffff;
  localparam logic [5:0]       RW_IDX        = 6'h02;
  localparam logic [5:0]       LEN_READ      = 6'h10;
  localparam logic [5:0]       LEN_WRITE     = 6'h20;
  localparam logic [4:0]       RESP_LAST     = 5'h1a;
  localparam logic [4:0]       CRC_BITS_RD   = 5'h0b;
  localparam logic [4:0]       CRC_BITS_WR   = 5'h1b;
  localparam logic [4:0]       CRC_BITS_RESP = 5'h16;
  localparam logic [2:0]       CRC_INIT      = 3'h7;
  localparam logic [1:0]       SYNC_CODE     = 2'h0;
  localparam logic [3:0]       TGT_BCAST     = 4'h0;
  localparam logic [5:0]       ACCESS_ADDR   = 6'h3f;
  localparam logic [15:0]      ACCESS_CODE   = 16'h62d2;
  localparam logic [5:0]       REG_READBACK_LOW_WORD = 6'h10;
  localparam logic [5:0]       REG_ANGLE_RESULT      = 6'h20;
  localparam logic [2:0]       SYNC_RST      = 3'h4;
  localparam logic [5:0]       ADDR_RST      = 6'h00;

  // one decoded manchester event from the receiver
  typedef struct packed {
    logic start;
    logic vld;
    logic val;
    logic tmo;
  } msl_rxbit_t;

  // status field of a read response
  typedef struct packed {
    logic [1:0] id;
    logic       bc;
    logic       ae;
    logic       ovr;
    logic       crc;
  } msl_status_t;

  function automatic logic [2:0] crc3(input logic [29:0] v, input logic [4:0] nb);
    logic [2:0] c;
    logic       d;
    c = CRC_INIT;
    for (int i = 29; i >= 0; i--) begin
      if (i < int'(nb)) begin
        d = v[i];
        c = {c[1], (c[2] ^ d) ^ c[0], c[2] ^ d};
      end
    end
    return c;
  endfunction

endpackage

/* File: core/msl_mrx.sv */
// manchester bit receiver with bit timing recovered from the first sync bit
`timescale 1ns/100ps
`default_nettype none
module msl_mrx (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  input  wire logic                      line,
  output msl_pkg::msl_rxbit_t            rx,
  output logic [msl_pkg::CNT_W-1:0]      half
);
  import msl_pkg::*;

  typedef enum {RX_IDLE, RX_MEAS, RX_RUN} msl_rx_st_t;

  msl_rx_st_t       st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, half_q, half_d;
  logic             prev_q;
  msl_rxbit_t       out_q, out_d;
  logic             rise, fall;
  logic [CNT_W:0]   win_lo, win_hi;

  assign rx   = out_q;
  assign half = half_q;

  // ****************************************************************
  // edge tracking
  // ****************************************************************
  always_comb begin
    rise   = line & ~prev_q;
    fall   = ~line & prev_q;
    // edges before 3/4 bit are cell boundaries, not data
    win_lo = {1'b0, half_q} + {2'b00, half_q[CNT_W-1:1]};
    win_hi = {half_q, 1'b0} + {2'b00, half_q[CNT_W-1:1]};
    st_d   = st_q;
    half_d = half_q;
    out_d  = '0;
    cnt_d  = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 16'h0001;
    case (st_q)
      RX_IDLE: begin
        cnt_d = '0;
        if (fall) begin
          st_d        = RX_MEAS;
          out_d.start = 1'b1;
        end
      end
      RX_MEAS: begin
        if (rise) begin
          half_d    = cnt_q + 16'h0001;
          cnt_d     = '0;
          st_d      = RX_RUN;
          out_d.vld = 1'b1;
        end else if (cnt_q == CNT_MAX) begin
          st_d      = RX_IDLE;
          out_d.tmo = 1'b1;
        end
      end
      RX_RUN: begin
        if ((rise || fall) && {1'b0, cnt_q} >= win_lo) begin
          out_d.vld = 1'b1;
          out_d.val = fall;
          cnt_d     = '0;
        end else if ({1'b0, cnt_q} >= win_hi) begin
          st_d      = RX_IDLE;
          out_d.tmo = 1'b1;
        end
      end
      default: st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= RX_IDLE;
      cnt_q  <= '0;
      half_q <= 16'h0001;
      prev_q <= 1'b1;
      out_q  <= '0;
    end else if (clk_en) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      half_q <= half_d;
      prev_q <= line;
      out_q  <= out_d;
    end
  end

endmodule // msl_mrx
`default_nettype wire

/* File: verif/msl_ctrl_model.sv */
// controller model: manchester frames on the supply line, response capture
`timescale 1ns/100ps
`default_nettype none
module msl_ctrl_model #(
  parameter int HALF = 16
) (
  input  wire logic ref_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output var  logic vcc_rx
);
  import msl_pkg::*;
  logic pin_lvl;

  // ****************************************************************
  // pin level and idle supply line
  // ****************************************************************
  // open-drain, pull-up
  assign pin_lvl = pin_oe ? pin_out : 1'b1;
  initial vcc_rx = 1'b1;

  // ****************************************************************
  // frame helpers
  // ****************************************************************
  // seed 111, msb first
  function automatic logic [2:0] crc_of(input logic [26:0] v, input int nb);
    logic [2:0] c;
    c = 3'h7;
    for (int i = nb - 1; i >= 0; i--) begin
      c = {c[1], c[2] ^ v[i] ^ c[0], c[2] ^ v[i]};
    end
    return c;
  endfunction

  task automatic put_bit(input logic b);
    vcc_rx = b;
    repeat (HALF) @(negedge ref_clk);
    vcc_rx = !b;
    repeat (HALF) @(negedge ref_clk);
  endtask

  // keep below the frame length cuts it short, for abort cases
  task automatic send(input logic [26:0] body, input int nb, input logic crc_bad, input int keep);
    logic [31:0] fr;
    int          n;
    n  = nb + 5;
    // crc sent c2 first after the body
    fr = ({5'h00, body} << 3) | {29'h0, crc_of(body, nb) ^ {2'b00, crc_bad}};
    repeat (4 * HALF) @(negedge ref_clk);
    for (int i = n - 1; i >= n - keep; i--) begin
      put_bit(fr[i]);
    end
    vcc_rx = 1'b1;
  endtask

  // missing mid-cell edge leaves an unknown bit, so it never matches
  task automatic recv(output logic found, output logic [26:0] r, output int dly);
    found = 1'b0;
    r     = '0;
    dly   = 0;
    // start taken anywhere near the last cell end
    while (pin_lvl && dly < 3 * HALF) begin
      @(negedge ref_clk);
      dly++;
    end
    if (!pin_lvl) begin
      found = 1'b1;
      repeat (HALF / 2 - 1) @(negedge ref_clk);
      for (int i = 26; i >= 0; i--) begin
        r[i] = pin_lvl;
        repeat (HALF) @(negedge ref_clk);
        if (pin_lvl === r[i]) begin
          r[i] = 1'bx;
        end
        repeat (HALF) @(negedge ref_clk);
      end
    end
  endtask

endmodule // msl_ctrl_model
`default_nettype wire

/* File: verif/tb.sv */
// testbench for the manchester serial command link
`timescale 1ns/100ps
`default_nettype none
module tb;
  import msl_pkg::*;
  localparam int H = 16;
  logic        ref_clk = 1'b0;
  logic        reset_n;
  logic        clk_en;
  logic        vcc_rx;
  logic        pin_out;
  logic        pin_oe;
  logic        comm_mode;
  logic [1:0]  die_id;
  logic [5:0]  rd_addr;
  logic [15:0] rd_word;
  logic [5:0]  addrs [4];
  logic        found;
  logic [26:0] resp;
  int          dly;
  int          err_count;
  int          num_checks;

  msl_link dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .vcc_rx(vcc_rx),
                  .die_id(die_id), .rd_word(rd_word), .rd_addr(rd_addr), .pin_out(pin_out),
                  .pin_oe(pin_oe), .comm_mode(comm_mode));
  msl_ctrl_model #(.HALF(H)) ctrl_u (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
                                     .vcc_rx(vcc_rx));

  // ****************************************************************
  // clock and register contents
  // ****************************************************************
  always #20 ref_clk = ~ref_clk;

  function automatic logic [7:0] reg_byte(input logic [5:0] a);
    return {2'b10, a} ^ 8'h3c;
  endfunction

  always @(negedge ref_clk) begin
    rd_word <= {reg_byte({rd_addr[5:1], 1'b0}), reg_byte({rd_addr[5:1], 1'b1})};
  end

  // ****************************************************************
  // compare, access and report tasks
  // ****************************************************************
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic read_cmd(input logic [3:0] tgt, input logic [5:0] a, input logic crc_bad, input int keep);
    ctrl_u.send({16'h0000, 1'b1, tgt, a}, 11, crc_bad, keep);
  endtask

  task automatic write_cmd(input logic [3:0] tgt, input logic [15:0] d);
    ctrl_u.send({1'b0, tgt, ACCESS_ADDR, d}, 27, 1'b0, 32);
    repeat (8) @(negedge ref_clk);
  endtask

  // flg holds abort, overrun and crc-error in response order
  task automatic read_exp(input logic [3:0] tgt, input logic [5:0] a, input logic [2:0] flg);
    logic [15:0] d;
    logic [21:0] body;
    read_cmd(tgt, a, 1'b0, 16);
    d    = {a[0] ? 8'h00 : reg_byte(a), reg_byte({a[5:1], 1'b1})};
    body = {die_id, tgt == 4'h0, flg, d};
    ctrl_u.recv(found, resp, dly);
    check_word("response", {7'h00, body, ctrl_u.crc_of({5'h00, body}, 22)}, {5'h00, resp});
    check_flag("start window", 1'b1, found && dly <= H / 2);
    check_word("latched addr", {26'h0, a}, {26'h0, rd_addr});
  endtask

  task automatic expect_none(input string what);
    ctrl_u.recv(found, resp, dly);
    check_flag(what, 1'b0, found);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // hang guard
  // ****************************************************************
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    $display("MISMATCH run length expected finish seen limit");
    stop_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n    = 1'b0;
    clk_en     = 1'b1;
    die_id     = 2'h0;
    err_count  = 0;
    num_checks = 0;
    addrs      = '{6'h20, 6'h11, 6'h10, 6'h21};
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    check_flag("mode after reset", 1'b0, comm_mode);

    read_cmd(4'h1, REG_ANGLE_RESULT, 1'b0, 16);
    expect_none("read out of mode");
    end_test("no mode");

    write_cmd(4'h1, ACCESS_CODE);
    check_flag("mode entered", 1'b1, comm_mode);
    end_test("access");

    for (int k = 0; k < 4; k++) begin
      die_id = 2'(k);
      repeat (4) @(negedge ref_clk);
      read_exp(4'h1 << k, addrs[k], 3'b000);
    end
    read_cmd(4'h5, REG_ANGLE_RESULT, 1'b0, 16);
    expect_none("unselected die");
    read_exp(4'h0, REG_READBACK_LOW_WORD, 3'b000);
    end_test("reads");

    read_cmd(4'h8, REG_ANGLE_RESULT, 1'b1, 16);
    expect_none("bad crc read");
    read_exp(4'h8, REG_ANGLE_RESULT, 3'b001);
    read_exp(4'h8, REG_ANGLE_RESULT, 3'b000);
    end_test("crc error");

    read_cmd(4'h8, REG_ANGLE_RESULT, 1'b0, 9);
    expect_none("cut frame");
    read_exp(4'h8, 6'h07, 3'b100);
    read_exp(4'h8, 6'h07, 3'b000);
    // sync pair 01 instead of 00 is discarded as an abort
    ctrl_u.send({16'h0001, 1'b1, 4'h8, REG_ANGLE_RESULT}, 11, 1'b0, 16);
    expect_none("bad sync");
    read_exp(4'h8, 6'h07, 3'b100);
    end_test("abort");

    read_cmd(4'h8, REG_READBACK_LOW_WORD, 1'b0, 16);
    fork
      ctrl_u.recv(found, resp, dly);
      begin
        repeat (2 * H) @(negedge ref_clk);
        read_cmd(4'h8, REG_ANGLE_RESULT, 1'b0, 16);
      end
    join
    check_flag("first response", 1'b1, found);
    expect_none("late command");
    read_exp(4'h8, REG_ANGLE_RESULT, 3'b010);
    read_exp(4'h8, REG_ANGLE_RESULT, 3'b000);
    end_test("overrun");

    write_cmd(4'h1, 16'h0000);
    check_flag("mode left", 1'b0, comm_mode);
    read_cmd(4'h8, REG_ANGLE_RESULT, 1'b0, 16);
    expect_none("read after exit");
    end_test("exit");
    stop_test();
  end

endmodule // tb
`default_nettype wire
